//--- src/sff_serial_frame.sv
// Serial channel with programmable frame format and baud prescaler.
// Function
// - Parity off: none added or checked.
// - Transmitter appends parity of chosen sense.
// - Receiver checks parity of chosen sense.
// - Odd/even only matters async with parity.
// - Even parity: ones count even.
// - Odd parity: ones count odd.
// - Stop setting 0 sends one stop bit.
// - Stop setting 1 sends two stop bits.
// - Clocked mode sends no stop bits.
// - Receiver checks only first stop bit.
// - Low after first stop starts next character.
// - Multiprocessor framing overrides parity settings.
// - Multiprocessor framing void in clocked mode.
// - Prescaler picks clock /1 /4 /16 /64.
// - Mode bit: 0 asynchronous, 1 clocked.
// - Clocked mode never adds parity.
// - Seven or eight bits async, eight clocked.
//
// Decided for this implementation: the register addresses and the strobed register port.
module sff_serial_frame
  import sff_pkg::*;
(
  // Clock and reset.
  input  wire logic              ref_clk,
  input  wire logic              arst_n,
  // Register port.
  input  wire logic [REG_AW-1:0] reg_addr,
  input  wire logic [REG_DW-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [REG_DW-1:0]      reg_rdata,
  // Transmit stream.
  input  wire logic              tx_valid,
  input  wire logic [7:0]        tx_data,
  output logic                   tx_ready,
  // Receive stream.
  output logic                   rx_valid,
  output logic [7:0]             rx_data,
  output logic                   rx_parity_err,
  output logic                   rx_frame_err,
  input  wire logic              rx_ready,
  // Line pins.
  output logic                   txd,
  output logic                   sclk,
  input  wire logic              rxd
);

  logic [7:0]           mode_q, ctrl_q;
  logic [5:0]           stat_q;
  logic [5:0]           presc_q;
  logic                 ptick;
  sff_state_t           tx_st_q, rx_st_q;
  logic [7:0]           tx_cfg_q, rx_cfg_q, tx_sh_q, rx_sh_q;
  logic [3:0]           tx_tk_q, rx_tk_q, tx_cnt_q, rx_cnt_q;
  logic                 tx_par_q, tx_stop2_q, tx_bit_end;
  logic                 rxd_s1_q, rxd_s2_q, rxd_s3_q, rxd_f_q, rxd_prev_q;
  logic                 rx_push_q, rx_perr_q, rx_ferr_q, buf_in_ready;
  logic [RX_WORD_W-1:0] rx_word_q, buf_out;
  logic                 sync_sample;

  // Baud prescaler: one tick every 1, 4, 16 or 64 clocks.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      presc_q <= PRESC_DIV1;
    end else if (presc_q >= presc_limit(mode_q[MODE_CKS_HI:MODE_CKS_LO])) begin
      presc_q <= PRESC_DIV1;
    end else begin
      presc_q <= presc_q + 6'h01;
    end
  end

  assign ptick = (presc_q >= presc_limit(mode_q[MODE_CKS_HI:MODE_CKS_LO]));

  // Mode and control registers.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_q <= MODE_RESET;
      ctrl_q <= CTRL_RESET;
    end else if (reg_wr) begin
      if (reg_addr == OFS_MODE) begin
        mode_q <= reg_wdata;
      end else if (reg_addr == OFS_CTRL) begin
        ctrl_q <= reg_wdata;
      end
    end
  end

  // Status: the error flags are sticky, and a new event wins over a write-one clear in the same cycle.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      stat_q <= 6'h00;
    end else begin
      if (reg_wr && reg_addr == OFS_STAT) begin
        stat_q[STAT_FRM_ERR:STAT_OVERRUN] <= stat_q[STAT_FRM_ERR:STAT_OVERRUN]
                                             & ~reg_wdata[STAT_FRM_ERR:STAT_OVERRUN]
                                             | {rx_push_q & rx_ferr_q,
                                                rx_push_q & rx_perr_q,
                                                rx_push_q & ~buf_in_ready};
      end else begin
        stat_q[STAT_FRM_ERR:STAT_OVERRUN] <= stat_q[STAT_FRM_ERR:STAT_OVERRUN]
                                             | {rx_push_q & rx_ferr_q,
                                                rx_push_q & rx_perr_q,
                                                rx_push_q & ~buf_in_ready};
      end
      stat_q[STAT_TX_BUSY] <= (tx_st_q != ST_IDLE);
      stat_q[STAT_RX_BUSY] <= (rx_st_q != ST_IDLE);
      if (rx_st_q == ST_PAR && rx_cfg_q[MODE_MP] && ptick && rx_tk_q == OVS_LAST) begin
        stat_q[STAT_MPB] <= rxd_f_q;
      end
    end
  end

  // Read data stands only in the cycle after the read strobe.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else if (!reg_rd) begin
      reg_rdata <= 8'h00;
    end else if (reg_addr == OFS_MODE) begin
      reg_rdata <= mode_q;
    end else if (reg_addr == OFS_CTRL) begin
      reg_rdata <= ctrl_q;
    end else if (reg_addr == OFS_STAT) begin
      reg_rdata <= {2'h0, stat_q};
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Transmitter. The format is frozen at the start of each character, so a
  // mode write during a frame affects the next one, except the prescaler select, which changes the bit rate at once.
  assign tx_bit_end = ptick && (tx_tk_q == OVS_LAST);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_st_q    <= ST_IDLE;
      tx_cfg_q   <= MODE_RESET;
      tx_sh_q    <= 8'h00;
      tx_tk_q    <= 4'h0;
      tx_cnt_q   <= 4'h0;
      tx_par_q   <= 1'b0;
      tx_stop2_q <= 1'b0;
    end else begin
      if (tx_st_q != ST_IDLE && ptick) begin
        tx_tk_q <= tx_tk_q + 4'h1;
      end
      case (tx_st_q)
        ST_IDLE: begin
          if (tx_valid && tx_ready) begin
            tx_cfg_q   <= eff_mode(mode_q);
            tx_sh_q    <= tx_data;
            tx_par_q   <= mode_q[MODE_MP] ? ctrl_q[CTRL_MPB]
                          : char_parity(tx_data, mode_q[MODE_CHR], mode_q[MODE_ODD]);
            tx_tk_q    <= 4'h0;
            tx_cnt_q   <= 4'h0;
            tx_stop2_q <= 1'b0;
            tx_st_q    <= mode_q[MODE_SYNC] ? ST_DATA : ST_START;
          end
        end
        ST_START: begin
          if (tx_bit_end) begin
            tx_st_q <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (tx_bit_end) begin
            tx_sh_q  <= {1'b0, tx_sh_q[7:1]};
            tx_cnt_q <= tx_cnt_q + 4'h1;
            if (tx_cnt_q == (tx_cfg_q[MODE_CHR] ? BITS_SHORT : BITS_LONG) - 4'h1) begin
              if (tx_cfg_q[MODE_PE] || tx_cfg_q[MODE_MP]) begin
                tx_st_q <= ST_PAR;
              end else if (tx_cfg_q[MODE_SYNC]) begin
                tx_st_q <= ST_IDLE;
              end else begin
                tx_st_q <= ST_STOP;
              end
            end
          end
        end
        ST_PAR: begin
          if (tx_bit_end) begin
            tx_st_q <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (tx_bit_end) begin
            if (tx_cfg_q[MODE_STOP] && !tx_stop2_q) begin
              tx_stop2_q <= 1'b1;
            end else begin
              tx_st_q <= ST_IDLE;
            end
          end
        end
        default: begin
          tx_st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Line outputs are registered, one clock behind the state.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      txd      <= 1'b1;
      sclk     <= 1'b1;
      tx_ready <= 1'b0;
    end else begin
      tx_ready <= (tx_st_q == ST_IDLE) && ctrl_q[CTRL_TX_EN] && !(tx_valid && tx_ready);
      sclk     <= !(tx_cfg_q[MODE_SYNC] && tx_st_q == ST_DATA && tx_tk_q <= OVS_HALF);
      case (tx_st_q)
        ST_START: txd <= 1'b0;
        ST_DATA:  txd <= tx_sh_q[0];
        ST_PAR:   txd <= tx_par_q;
        default:  txd <= 1'b1;
      endcase
    end
  end

  // Line input synchroniser; a change counts once stages two and three agree.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rxd_s1_q   <= 1'b1;
      rxd_s2_q   <= 1'b1;
      rxd_s3_q   <= 1'b1;
      rxd_f_q    <= 1'b1;
      rxd_prev_q <= 1'b1;
    end else begin
      rxd_s1_q   <= rxd;
      rxd_s2_q   <= rxd_s1_q;
      rxd_s3_q   <= rxd_s2_q;
      rxd_prev_q <= rxd_f_q;
      if (rxd_s2_q == rxd_s3_q) begin
        rxd_f_q <= rxd_s3_q;
      end
    end
  end

  // Clocked mode receives on the transmitter's own bit clock, at mid bit.
  assign sync_sample = tx_cfg_q[MODE_SYNC] && tx_st_q == ST_DATA && ptick && tx_tk_q == OVS_HALF;

  // Receiver. Async bits are sampled at mid bit, 8 ticks after the start edge.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_st_q   <= ST_IDLE;
      rx_cfg_q  <= MODE_RESET;
      rx_sh_q   <= 8'h00;
      rx_tk_q   <= 4'h0;
      rx_cnt_q  <= 4'h0;
      rx_perr_q <= 1'b0;
      rx_ferr_q <= 1'b0;
      rx_push_q <= 1'b0;
      rx_word_q <= '0;
    end else begin
      rx_push_q <= 1'b0;
      if (rx_st_q != ST_IDLE && ptick) begin
        rx_tk_q <= rx_tk_q + 4'h1;
      end
      case (rx_st_q)
        ST_IDLE: begin
          rx_cfg_q  <= eff_mode(mode_q);
          rx_tk_q   <= 4'h0;
          rx_cnt_q  <= 4'h0;
          rx_perr_q <= 1'b0;
          rx_ferr_q <= 1'b0;
          if (ctrl_q[CTRL_RX_EN] && mode_q[MODE_SYNC] && sync_sample) begin
            rx_sh_q  <= {rxd_f_q, rx_sh_q[7:1]};
            rx_cnt_q <= 4'h1;
            rx_st_q  <= ST_DATA;
          end else if (ctrl_q[CTRL_RX_EN] && !mode_q[MODE_SYNC] && rxd_prev_q && !rxd_f_q) begin
            rx_st_q <= ST_START;
          end
        end
        ST_START: begin
          if (ptick && rx_tk_q == OVS_HALF) begin
            rx_tk_q <= 4'h0;
            rx_st_q <= rxd_f_q ? ST_IDLE : ST_DATA;
          end
        end
        ST_DATA: begin
          if (rx_cfg_q[MODE_SYNC] ? sync_sample : (ptick && rx_tk_q == OVS_LAST)) begin
            rx_sh_q  <= {rxd_f_q, rx_sh_q[7:1]};
            rx_cnt_q <= rx_cnt_q + 4'h1;
            if (rx_cnt_q == (rx_cfg_q[MODE_CHR] ? BITS_SHORT : BITS_LONG) - 4'h1) begin
              if (rx_cfg_q[MODE_SYNC]) begin
                rx_push_q <= 1'b1;
                rx_word_q <= {2'b00, rxd_f_q, rx_sh_q[7:1]};
                rx_st_q   <= ST_IDLE;
              end else if (rx_cfg_q[MODE_PE] || rx_cfg_q[MODE_MP]) begin
                rx_st_q <= ST_PAR;
              end else begin
                rx_st_q <= ST_STOP;
              end
            end
          end
        end
        ST_PAR: begin
          if (ptick && rx_tk_q == OVS_LAST) begin
            rx_perr_q <= rx_cfg_q[MODE_PE]
                         && (char_parity(rx_cfg_q[MODE_CHR] ? {1'b0, rx_sh_q[7:1]} : rx_sh_q,
                                         1'b0, rx_cfg_q[MODE_ODD]) != rxd_f_q);
            rx_st_q   <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (ptick && rx_tk_q == OVS_LAST) begin
            rx_ferr_q <= !rxd_f_q;
            rx_push_q <= 1'b1;
            rx_word_q <= {rx_perr_q, !rxd_f_q,
                          rx_cfg_q[MODE_CHR] ? {1'b0, rx_sh_q[7:1]} : rx_sh_q};
            rx_st_q   <= ST_IDLE;
          end
        end
        default: begin
          rx_st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // A word pushed while both entries are held is dropped and flagged.
  sff_pair_buf #(
    .W (RX_WORD_W)
  ) u_rx_buf (
    .ref_clk   (ref_clk),
    .arst_n    (arst_n),
    .in_valid  (rx_push_q),
    .in_data   (rx_word_q),
    .in_ready  (buf_in_ready),
    .out_valid (rx_valid),
    .out_data  (buf_out),
    .out_ready (rx_ready)
  );

  assign rx_data       = buf_out[7:0];
  assign rx_frame_err  = buf_out[8];
  assign rx_parity_err = buf_out[9];

endmodule : sff_serial_frame

//--- common/sff_pkg.sv
// Shared constants, types and helpers of the serial frame format block.
package sff_pkg;

  localparam int          REG_AW        = 2;
  localparam int          REG_DW        = 8;
  localparam logic [1:0]  OFS_MODE      = 2'h0;
  localparam logic [1:0]  OFS_CTRL      = 2'h1;
  localparam logic [1:0]  OFS_STAT      = 2'h2;

  localparam int          MODE_CKS_LO   = 0;
  localparam int          MODE_CKS_HI   = 1;
  localparam int          MODE_MP       = 2;
  localparam int          MODE_STOP     = 3;
  localparam int          MODE_ODD      = 4;
  localparam int          MODE_PE       = 5;
  localparam int          MODE_CHR      = 6;
  localparam int          MODE_SYNC     = 7;
  localparam logic [7:0]  MODE_RESET    = 8'h00;

  localparam int          CTRL_TX_EN    = 0;
  localparam int          CTRL_RX_EN    = 1;
  localparam int          CTRL_MPB      = 2;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;

  localparam int          STAT_TX_BUSY  = 0;
  localparam int          STAT_RX_BUSY  = 1;
  localparam int          STAT_OVERRUN  = 2;
  localparam int          STAT_PAR_ERR  = 3;
  localparam int          STAT_FRM_ERR  = 4;
  localparam int          STAT_MPB      = 5;

  localparam logic [5:0]  PRESC_DIV1    = 6'h00;
  localparam logic [5:0]  PRESC_DIV4    = 6'h03;
  localparam logic [5:0]  PRESC_DIV16   = 6'h0f;
  localparam logic [5:0]  PRESC_DIV64   = 6'h3f;

  localparam logic [3:0]  OVS_LAST      = 4'hf;
  localparam logic [3:0]  OVS_HALF      = 4'h7;
  localparam logic [3:0]  BITS_LONG     = 4'h8;
  localparam logic [3:0]  BITS_SHORT    = 4'h7;
  localparam int          RX_WORD_W     = 10;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_START = 3'b001,
    ST_DATA  = 3'b010,
    ST_PAR   = 3'b011,
    ST_STOP  = 3'b100
  } sff_state_t;

  function automatic logic [5:0] presc_limit(input logic [1:0] sel);
    case (sel)
      2'h0:    presc_limit = PRESC_DIV1;
      2'h1:    presc_limit = PRESC_DIV4;
      2'h2:    presc_limit = PRESC_DIV16;
      default: presc_limit = PRESC_DIV64;
    endcase
  endfunction : presc_limit

  // Clears every setting that the current combination makes void.
  function automatic logic [7:0] eff_mode(input logic [7:0] m);
    logic [7:0] e;
    e = m;
    if (e[MODE_SYNC]) begin
      e[MODE_PE]   = 1'b0;
      e[MODE_ODD]  = 1'b0;
      e[MODE_STOP] = 1'b0;
      e[MODE_MP]   = 1'b0;
      e[MODE_CHR]  = 1'b0;
    end
    if (e[MODE_MP]) begin
      e[MODE_PE]   = 1'b0;
    end
    if (!e[MODE_PE]) begin
      e[MODE_ODD]  = 1'b0;
    end
    eff_mode = e;
  endfunction : eff_mode

  function automatic logic char_parity(input logic [7:0] d, input logic seven,
                                       input logic odd);
    logic [7:0] m;
    m = d;
    if (seven) begin
      m[7] = 1'b0;
    end
    char_parity = (^m) ^ odd;
  endfunction : char_parity

endpackage : sff_pkg

//--- src/sff_pair_buf.sv
// Two-entry valid/ready buffer with registered outputs.
module sff_pair_buf #(
  parameter int W = 10
) (
  // Clock and reset.
  input  wire logic         ref_clk,
  input  wire logic         arst_n,
  // Filling side.
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  // Draining side.
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);

  logic         head_v_q, head_v_d, spare_v_q, spare_v_d;
  logic [W-1:0] head_q, head_d, spare_q, spare_d;
  logic         pop, push;

  assign pop       = head_v_q & out_ready;
  assign push      = in_valid & in_ready;
  assign out_valid = head_v_q;
  assign out_data  = head_q;

  always_comb begin
    head_v_d  = head_v_q;
    spare_v_d = spare_v_q;
    head_d    = head_q;
    spare_d   = spare_q;
    if (pop) begin
      if (spare_v_q) begin
        head_d    = spare_q;
        spare_v_d = 1'b0;
      end else begin
        head_v_d  = 1'b0;
      end
    end
    if (push) begin
      if (!head_v_d) begin
        head_d   = in_data;
        head_v_d = 1'b1;
      end else begin
        spare_d   = in_data;
        spare_v_d = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      head_v_q  <= 1'b0;
      spare_v_q <= 1'b0;
      head_q    <= '0;
      spare_q   <= '0;
      in_ready  <= 1'b1;
    end else begin
      head_v_q  <= head_v_d;
      spare_v_q <= spare_v_d;
      head_q    <= head_d;
      spare_q   <= spare_d;
      in_ready  <= ~spare_v_d;
    end
  end

endmodule : sff_pair_buf

//--- bench/sff_remote_node.sv
// Model of the remote serial node on the line pins.
module sff_remote_node (
  // Clock.
  input  wire logic ref_clk,
  // Line pins.
  input  wire logic txd,
  input  wire logic sclk,
  output logic      rxd
);
  timeunit 1ns;
  timeprecision 1ns;

  initial rxd = 1'b1;

  // Sends n bits first bit first, bc clocks each; a low last bit falls back to mark.
  // Frames ending on mark leave the line alone, so a next call can follow at once.
  task automatic send(input logic [15:0] b, input int n, input int bc);
    for (int i = 0; i < n; i++) begin
      rxd <= b[i];
      repeat (bc) @(posedge ref_clk);
    end
    if (!b[n - 1]) begin
      rxd <= 1'b1;
    end
  endtask : send

  // Samples an asynchronous frame at mid bit, start bit first.
  task automatic grab(input int n, input int bc, output logic [15:0] b);
    b = 16'h0000;
    @(negedge txd);
    repeat (bc / 2) @(posedge ref_clk);
    for (int i = 0; i < n; i++) begin
      b[i] = txd;
      repeat (bc) @(posedge ref_clk);
    end
  endtask : grab

  // Clocked mode has no start bit, so data is taken on the rising serial clock.
  task automatic grab_sync(output logic [15:0] b);
    b = 16'h0000;
    for (int i = 0; i < 8; i++) begin
      @(posedge sclk);
      b[i] = txd;
    end
  endtask : grab_sync
endmodule : sff_remote_node

//--- bench/sff_serial_frame_props.sv
// Port-level assertions for the serial frame block.
module sff_serial_frame_props
  import sff_pkg::*;
(
  // Clock and reset.
  input wire logic              ref_clk,
  input wire logic              arst_n,
  // Register port.
  input wire logic [REG_AW-1:0] reg_addr,
  input wire logic [REG_DW-1:0] reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [REG_DW-1:0] reg_rdata,
  // Streams.
  input wire logic              tx_valid,
  input wire logic [7:0]        tx_data,
  input wire logic              tx_ready,
  input wire logic              rx_valid,
  input wire logic [7:0]        rx_data,
  input wire logic              rx_parity_err,
  input wire logic              rx_frame_err,
  input wire logic              rx_ready,
  // Line pins.
  input wire logic              txd,
  input wire logic              sclk,
  input wire logic              rxd
);
  logic [7:0] mode_q;
  logic [7:0] ctrl_q;

  // Shadow settings, so that checks know the frame format in force.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_q <= MODE_RESET;
      ctrl_q <= CTRL_RESET;
    end else if (reg_wr && reg_addr == OFS_MODE) begin
      mode_q <= reg_wdata;
    end else if (reg_wr && reg_addr == OFS_CTRL) begin
      ctrl_q <= reg_wdata;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  sequence s_take;
    tx_valid && tx_ready;
  endsequence
  sequence s_start_bit;
    ##2 (!txd) [*8];
  endsequence

  AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("Read data not zero outside a read answer.");
  AST_RD_MODE: assert property (reg_rd && reg_addr == OFS_MODE
      |=> reg_rdata == $past(mode_q))
    else $error("Mode read differs from last write.");
  AST_UNMAPPED: assert property (reg_rd && reg_addr == 2'h3 |=> reg_rdata == 8'h00)
    else $error("Unmapped read not zero.");
  AST_IDLE: assert property (tx_ready |-> txd && sclk)
    else $error("Line not at mark while idle.");
  AST_START: assert property (s_take ##0 !mode_q[MODE_SYNC] |-> s_start_bit)
    else $error("Missing start bit in asynchronous mode.");
  AST_TAKE: assert property (s_take |=> (!tx_ready) [*8])
    else $error("Ready back too soon after a take.");
  AST_TX_OFF: assert property (!ctrl_q[CTRL_TX_EN] && !$past(ctrl_q[CTRL_TX_EN])
      |-> !tx_ready)
    else $error("Ready while transmit disabled.");
  AST_RX_HOLD: assert property (rx_valid && !rx_ready |=>
      rx_valid && $stable(rx_data) && $stable(rx_parity_err) && $stable(rx_frame_err))
    else $error("Receive word changed while stalled.");
endmodule : sff_serial_frame_props

bind sff_serial_frame sff_serial_frame_props props_u (
  .ref_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .tx_valid, .tx_data, .tx_ready, .rx_valid, .rx_data, .rx_parity_err,
  .rx_frame_err, .rx_ready, .txd, .sclk, .rxd
);

//--- bench/testbench.sv
// Self-checking bench of the serial frame block.
module testbench import sff_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  logic              ref_clk, arst_n, reg_wr, reg_rd, tx_valid, tx_ready, rx_valid;
  logic              rx_parity_err, rx_frame_err, rx_ready, txd, sclk, rxd;
  logic [REG_AW-1:0] reg_addr;
  logic [7:0]        reg_wdata, reg_rdata, tx_data, rx_data, rv, d0, d1;
  int                num_errors, samples_checked;
  localparam logic [7:0] TXM [8] = '{8'h00, 8'h21, 8'h30, 8'h68, 8'h26, 8'hb4, 8'h8b, 8'h13};
  localparam logic [7:0] RXM [6] = '{8'h20, 8'h30, 8'h10, 8'h60, 8'h00, 8'h24};
  localparam logic [5:0] RXBAD   = 6'h29;
  localparam logic [5:0] RXSTOP  = 6'h2f;

  sff_serial_frame dut_u (.ref_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .tx_valid, .tx_data, .tx_ready, .rx_valid, .rx_data, .rx_parity_err,
    .rx_frame_err, .rx_ready, .txd, .sclk, .rxd);
  sff_remote_node rn_u (.ref_clk, .txd, .sclk, .rxd);

  always #25 ref_clk = ~ref_clk;

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask : wr

  task automatic rd(input logic [1:0] a, output logic [7:0] q);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    q = reg_rdata;
    @(posedge ref_clk);
  endtask : rd

  function automatic int bit_clk(input logic [1:0] c);
    return 16 << (2 * c);
  endfunction : bit_clk

  // Expected line bits, first bit in bit 0; unused high bits stay at mark.
  function automatic int exp_frame(input logic [7:0] m, input logic [7:0] d, input logic mpb,
                                   output logic [15:0] b);
    int   n;
    logic p;
    b = 16'hffff;
    if (m[MODE_SYNC]) begin
      b[7:0] = d;
      return 8;
    end
    b[0] = 1'b0;
    n = m[MODE_CHR] ? 7 : 8;
    p = m[MODE_ODD];
    for (int i = 0; i < n; i++) begin
      b[i + 1] = d[i];
      p = p ^ d[i];
    end
    n++;
    if (m[MODE_MP]) begin
      b[n] = mpb;
      n++;
    end else if (m[MODE_PE]) begin
      b[n] = p;
      n++;
    end
    return n + 1 + m[MODE_STOP];
  endfunction : exp_frame

  task automatic tx_case(input logic [7:0] m, input logic [7:0] d, input logic mpb);
    logic [15:0] eb, gb, msk;
    int          n, bc, cnt;
    n   = exp_frame(m, d, mpb, eb);
    bc  = bit_clk(m[1:0]);
    msk = (16'h0001 << n) - 16'h0001;
    wr(OFS_CTRL, {5'h00, mpb, 2'h1});
    wr(OFS_MODE, m);
    tx_data  <= d;
    tx_valid <= 1'b1;
    fork
      if (m[MODE_SYNC]) rn_u.grab_sync(gb);
      else rn_u.grab(n, bc, gb);
      begin
        cnt = 0;
        @(negedge ref_clk);
        while (tx_ready !== 1'b1 && cnt < 100) begin
          @(negedge ref_clk);
          cnt++;
        end
        @(posedge ref_clk);
        tx_valid <= 1'b0;
        cnt = 0;
        do begin
          @(negedge ref_clk);
          cnt++;
        end while (tx_ready !== 1'b1 && cnt < 20000);
      end
    join
    @(posedge ref_clk);
    // The first tick of a frame may fall anywhere in a prescaler period, so the
    // frame can end up to one period minus one clock early.
    chk("tx frame", eb & msk, gb & msk);
    chk("tx length", 16'h0001, 16'(cnt >= n * bc - bc / 16 + 3
        && cnt <= n * bc + 2));
  endtask : tx_case

  // Only one stop bit goes on the wire; a second one is optional to the receiver.
  task automatic rx_frame(input logic [7:0] m, input logic [7:0] d, input logic bad,
                          input logic stop);
    logic [15:0] b;
    int          n;
    n = exp_frame(m, d, 1'b0, b) - m[MODE_STOP];
    b[n - 1] = stop;
    if (bad) b[n - 2] = ~b[n - 2];
    rn_u.send(b, n, bit_clk(m[1:0]));
  endtask : rx_frame

  task automatic rx_take(input logic [7:0] d, input logic pe, input logic fe);
    int w;
    w = 0;
    @(negedge ref_clk);
    while (rx_valid !== 1'b1 && w < 2000) begin
      @(negedge ref_clk);
      w++;
    end
    chk("rx valid", 16'h0001, {15'h0000, rx_valid});
    chk("rx data", d, rx_data);
    chk("rx parity", pe, rx_parity_err);
    chk("rx frame", fe, rx_frame_err);
    @(posedge ref_clk);
    rx_ready <= 1'b1;
    @(posedge ref_clk);
    rx_ready <= 1'b0;
    @(posedge ref_clk);
  endtask : rx_take

  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test

  initial begin
    repeat (40000) @(posedge ref_clk);
    num_errors++;
    end_of_test();
  end

  initial begin
    {ref_clk, arst_n, reg_wr, reg_rd, tx_valid, rx_ready} = 6'h00;
    reg_addr         = 2'h0;
    reg_wdata        = 8'h00;
    tx_data          = 8'h00;
    num_errors       = 0;
    samples_checked  = 0;
    rv               = 8'($urandom(32'h0079));
    repeat (6) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    rd(OFS_MODE, rv);
    chk("mode reset", MODE_RESET, rv);
    wr(2'h3, 8'h5a);
    rd(2'h3, rv);
    chk("unmapped read", 8'h00, rv);
    for (int i = 0; i < 4; i++) begin
      d0 = 8'($urandom);
      wr(OFS_MODE, d0);
      rd(OFS_MODE, rv);
      chk("mode readback", d0, rv);
    end
    for (int i = 0; i < 8; i++) tx_case(TXM[i], 8'($urandom), 1'($urandom));
    wr(OFS_CTRL, 8'h02);
    for (int i = 0; i < 6; i++) begin
      d0 = 8'($urandom);
      wr(OFS_MODE, RXM[i]);
      rx_frame(RXM[i], d0, RXBAD[i], RXSTOP[i]);
      rx_take(RXM[i][MODE_CHR] ? {1'b0, d0[6:0]} : d0,
              RXBAD[i] && RXM[i][MODE_PE] && !RXM[i][MODE_MP], !RXSTOP[i]);
    end
    rd(OFS_STAT, rv);
    chk("status sticky", 4'he, rv[5:2]);
    wr(OFS_STAT, 8'h1c);
    wr(OFS_MODE, 8'h08);
    d0 = 8'($urandom);
    d1 = 8'($urandom);
    rx_frame(8'h08, d0, 1'b0, 1'b1);
    rx_frame(8'h08, d1, 1'b0, 1'b1);
    rx_frame(8'h08, 8'($urandom), 1'b0, 1'b1);
    repeat (40) @(posedge ref_clk);
    rd(OFS_STAT, rv);
    chk("overrun", 3'h1, rv[4:2]);
    rx_take(d0, 1'b0, 1'b0);
    rx_take(d1, 1'b0, 1'b0);
    end_of_test();
  end
endmodule : testbench
